// ---- hw/dio_map.vh ----
/*
  Register map, field positions and reset values of the digital I/O input
  status and bidirectional port block. Included by the design files.
  Assumes 16-bit word addresses on the peripheral bus.
*/
`ifndef DIO_MAP_VH
`define DIO_MAP_VH

// ----------------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------------
`define FRAME_BASE        16'h7090
`define FRAME_LAST        16'h709f
`define ADDR_STATUS_A     16'h7094
`define ADDR_STATUS_B     16'h7096
`define ADDR_PORT_A       16'h7098
`define ADDR_PORT_B       16'h709a
`define ADDR_PORT_C       16'h709c
`define ADDR_PORT_D       16'h709e

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define DIR_MSB           15
`define DIR_LSB           8
`define DATA_MSB          7
`define DATA_LSB          0
`define PORT_RESET        16'h0000
`define STATUS_RESET      16'h0000
`define READ_ZERO         16'h0000
`define DIR_RESET         8'h00
`define DATA_RESET        8'h00

// ----------------------------------------------------------------------------
// Address bits
// ----------------------------------------------------------------------------
`define WORD_ALIGN_BIT    0
`define PORT_SEL_MSB      2
`define PORT_SEL_LSB      1

`endif

// ---- hw/dio_ports.v ----
/*
  Digital I/O block: two 16-bit input status registers and four 8-pin
  bidirectional data/direction port registers on the 16-bit peripheral bus.
  Status lines and port pins pass a two-flop synchroniser before any read.
  Assumes a synchronous single-cycle bus: address, read and write strobes
  sampled on ref_clk; read data is registered and valid the cycle after rd_en.
  Assumes clk_en low freezes the whole block, bus strobes included.
  Assumes pins of port A sit in bits 7:0 of the pin vectors, B in 15:8,
  C in 23:16 and D in 31:24; an active-low enable marks a driven pin.
  Pins and status lines are asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "dio_map.vh"

// How it works
// - Status word A at 7094h reads 1 per bit where its input line is high, 0 where low.
// - Status word B at 7096h reports a second group of sixteen input lines the same way.
// - In each port register bits 15-8 set per-pin direction, 0 input and 1 output.
// - With direction 0 a data bit read returns the present pin level.
// - With direction 1 the data bit is the level driven onto the pin.
// - Four identical ports A to D, pin n direction at bit n+8 and data at bit n.
// - Reset clears every direction and data field so all pins start as inputs.
// - Registers are 16-bit words in data space within the frame 7090h to 709Fh.
module dio_ports #(
  parameter NPORTS = 4,
  parameter PINS   = 8
) (
  input  wire                   ref_clk,
  input  wire                   rst,
  input  wire                   clk_en,
  input  wire [15:0]            addr,
  input  wire                   wr_en,
  input  wire                   rd_en,
  input  wire [15:0]            wr_data,
  output reg  [15:0]            rd_data,
  output reg                    rd_valid,
  input  wire [15:0]            status_a_bits,
  input  wire [15:0]            status_b_bits,
  input  wire [NPORTS*PINS-1:0] port_pin_in,
  output reg  [NPORTS*PINS-1:0] port_pin_out,
  output reg  [NPORTS*PINS-1:0] port_pin_oe_n
);

  // --------------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------------
  wire [15:0]            status_a_sync;
  wire [15:0]            status_b_sync;
  wire [NPORTS*PINS-1:0] pin_sync_lvl;

  pin_sync #(.WIDTH(16)) sync_a (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (status_a_bits),
    .sync_out (status_a_sync)
  );

  pin_sync #(.WIDTH(16)) sync_b (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (status_b_bits),
    .sync_out (status_b_sync)
  );

  pin_sync #(.WIDTH(NPORTS*PINS)) sync_p (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (port_pin_in),
    .sync_out (pin_sync_lvl)
  );

  // --------------------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------------------
  localparam PIN_COUNT = NPORTS * PINS;
  localparam WORD_W    = 2 * PINS;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  // Odd or out-of-frame addresses match nothing: writes drop, reads give zero
  wire              in_frame;
  wire              word_aligned;
  wire              hit_status_a;
  wire              hit_status_b;
  wire              hit_port;
  wire [1:0]        port_sel;
  wire [NPORTS-1:0] port_onehot;
  wire              bus_write;
  wire              bus_read;

  assign in_frame     = (addr >= `FRAME_BASE) && (addr <= `FRAME_LAST);
  assign word_aligned = !addr[`WORD_ALIGN_BIT];
  assign hit_status_a = in_frame && (addr == `ADDR_STATUS_A);
  assign hit_status_b = in_frame && (addr == `ADDR_STATUS_B);
  assign hit_port     = in_frame && word_aligned &&
                        (addr >= `ADDR_PORT_A) && (addr <= `ADDR_PORT_D);
  assign port_sel     = addr[`PORT_SEL_MSB:`PORT_SEL_LSB];
  assign port_onehot  = {{(NPORTS-1){1'b0}}, 1'b1} << port_sel;
  assign bus_write    = clk_en && wr_en;
  assign bus_read     = clk_en && rd_en;

  // --------------------------------------------------------------------------
  // Write strobes
  // --------------------------------------------------------------------------
  // Status words have no storage, so a write there is simply dropped
  wire [NPORTS-1:0] port_wr;

  assign port_wr = {NPORTS{bus_write && hit_port}} & port_onehot;

  // --------------------------------------------------------------------------
  // Status words
  // --------------------------------------------------------------------------
  wire [15:0] status_a_word;
  wire [15:0] status_b_word;

  assign status_a_word = status_a_sync;
  assign status_b_word = status_b_sync;

  // --------------------------------------------------------------------------
  // Port registers
  // --------------------------------------------------------------------------
  wire [PIN_COUNT-1:0]     dir_flat;
  wire [PIN_COUNT-1:0]     data_flat;
  wire [NPORTS*WORD_W-1:0] port_word_flat;
  genvar                   k;

  generate
    for (k = 0; k < NPORTS; k = k + 1) begin : g_port
      reg  [PINS-1:0]   pin_direction_bits_ff;
      reg  [PINS-1:0]   pin_data_bits_ff;
      wire [PINS-1:0]   pin_lvl;
      wire [PINS-1:0]   data_view;
      wire [WORD_W-1:0] rd_word;

      // One write sets direction and data together, so a pin turned to
      // output never drives a stale level for a cycle
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          pin_direction_bits_ff <= `DIR_RESET;
          pin_data_bits_ff      <= `DATA_RESET;
        end else if (port_wr[k]) begin
          pin_direction_bits_ff <= wr_data[`DIR_MSB:`DIR_LSB];
          pin_data_bits_ff      <= wr_data[`DATA_MSB:`DATA_LSB];
        end
      end

      // Input pins show the synchronised level, output pins the stored value
      assign pin_lvl   = pin_sync_lvl[k*PINS +: PINS];
      assign data_view = (pin_direction_bits_ff & pin_data_bits_ff) |
                         (~pin_direction_bits_ff & pin_lvl);
      assign rd_word   = {pin_direction_bits_ff, data_view};

      assign dir_flat[k*PINS +: PINS]           = pin_direction_bits_ff;
      assign data_flat[k*PINS +: PINS]          = pin_data_bits_ff;
      assign port_word_flat[k*WORD_W +: WORD_W] = rd_word;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------
  // Registered so outputs come straight from flops; costs one cycle of latency
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port_pin_out  <= {PIN_COUNT{1'b0}};
      port_pin_oe_n <= {PIN_COUNT{1'b1}};
    end else if (clk_en) begin
      port_pin_out  <= data_flat;
      port_pin_oe_n <= ~dir_flat;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Source picked first so the priority of the decode lives in one place
  localparam [1:0] SRC_NONE     = 2'b00;
  localparam [1:0] SRC_STATUS_A = 2'b01;
  localparam [1:0] SRC_STATUS_B = 2'b10;
  localparam [1:0] SRC_PORT     = 2'b11;

  reg [1:0]  rd_src;
  reg [15:0] nxt_rd_data;

  always @* begin
    rd_src = SRC_NONE;
    if (hit_status_a) begin
      rd_src = SRC_STATUS_A;
    end else if (hit_status_b) begin
      rd_src = SRC_STATUS_B;
    end else if (hit_port) begin
      rd_src = SRC_PORT;
    end
  end

  always @* begin
    nxt_rd_data = `READ_ZERO;
    case (rd_src)
      SRC_STATUS_A: nxt_rd_data = status_a_word;
      SRC_STATUS_B: nxt_rd_data = status_b_word;
      SRC_PORT:     nxt_rd_data = port_word_flat[port_sel*WORD_W +: WORD_W];
      default:      nxt_rd_data = `READ_ZERO;
    endcase
  end

  // rd_data holds the last read so a slow master may pick it up late
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data  <= `READ_ZERO;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= rd_en;
      if (bus_read) begin
        rd_data <= nxt_rd_data;
      end
    end
  end

endmodule // dio_ports

// ---- hw/pin_sync.v ----
/*
  Two-flop synchroniser for a bus of asynchronous levels.
  Assumes the clock enable gates all state, reset is asynchronous active high.
*/
`timescale 1ns/1ps
`include "dio_map.vh"

module pin_sync #(
  parameter WIDTH = 16
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_ff;

  // First stage feeds only the second stage
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_ff  <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // pin_sync

// ---- verif/digital_io_input_and_bidir_ports_test.sv ----
/* Random bench for dio_ports; assumes one-cycle strobes, answer next cycle. */
`timescale 1ns/1ps
module digital_io_input_and_bidir_ports_test;
  logic        ref_clk = 0, rst = 1, clk_en = 1, wr_en = 0, rd_en = 0, rd_valid;
  logic [15:0] addr = 0, wr_data = 0, status_a_bits = 0, status_b_bits = 0, rd_data, q, d;
  logic [31:0] port_pin_in, port_pin_out, port_pin_oe_n, ext_level = 0, seed = 32'h911e;
  int          err_count = 0, tests_run = 0, p, n;
  always #20 ref_clk = ~ref_clk;
  dio_ports i_dut (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .clk_en        (clk_en),
    .addr          (addr),
    .wr_en         (wr_en),
    .rd_en         (rd_en),
    .wr_data       (wr_data),
    .rd_data       (rd_data),
    .rd_valid      (rd_valid),
    .status_a_bits (status_a_bits),
    .status_b_bits (status_b_bits),
    .port_pin_in   (port_pin_in),
    .port_pin_out  (port_pin_out),
    .port_pin_oe_n (port_pin_oe_n)
  );
  pin_model i_pins (
    .port_pin_out  (port_pin_out),
    .port_pin_oe_n (port_pin_oe_n),
    .ext_level     (ext_level),
    .port_pin_in   (port_pin_in)
  );
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [15:0] exp_port(logic [15:0] v, logic [7:0] pin);
    return {v[15:8], v[7:0] & v[15:8] | pin & ~v[15:8]};
  endfunction
  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", what, e, g);
    end
  endtask
  // Drive level only matters on pins set as outputs
  task automatic chk_pins(string what, logic [7:0] dir, logic [7:0] dat, logic [7:0] oe_n, logic [7:0] out);
    tests_run++;
    if (oe_n !== ~dir || (out & dir) !== (dat & dir)) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", what, {~dir, dat & dir}, {oe_n, out & dir});
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(logic [15:0] a, logic [15:0] v, logic rd);
    @(negedge ref_clk);
    addr = a;
    wr_data = v;
    {wr_en, rd_en} = {!rd, rd};
    @(negedge ref_clk);
    {wr_en, rd_en} = 2'b00;
    for (n = 0; rd && n < 4 && rd_valid !== 1'b1; n++)
      @(negedge ref_clk);
    if (n == 4) begin
      err_count++;
      print_verdict();
    end else
      q = rd_data;
  endtask
  initial begin
    logic [15:0] z [6] = '{16'h7098, 16'h709a, 16'h709c, 16'h709e, 16'h7095, 16'h70a0};
    repeat (20) @(negedge ref_clk);
    rst = 0;
    foreach (z[k]) begin
      bus(z[k], 0, 1);
      chk("zero read", 0, q);
    end
    for (int i = 0; i < 40; i++) begin
      p = rnd() % 4;
      d = i == 0 ? 16'hff00 : i == 1 ? 16'h00ff : rnd();
      ext_level = {rnd(), rnd()};
      status_a_bits = rnd();
      status_b_bits = rnd();
      bus(16'h7098 + 2 * p, d, 0);
      bus(16'h7094, ~status_a_bits, 0);
      repeat (3) @(negedge ref_clk);
      bus(16'h7098 + 2 * p, 0, 1);
      chk("port", exp_port(d, ext_level[8 * p +: 8]), q);
      chk_pins("pins", d[15:8], d[7:0], port_pin_oe_n[8 * p +: 8], port_pin_out[8 * p +: 8]);
      bus(16'h7094, 0, 1);
      chk("status a", status_a_bits, q);
      bus(16'h7096, 0, 1);
      chk("status b", status_b_bits, q);
    end
    // A write while clk_en is low must leave port A untouched
    bus(16'h7098, 16'h0f55, 0);
    repeat (2) @(negedge ref_clk);
    clk_en = 0;
    bus(16'h7098, 16'hf0aa, 0);
    repeat (4) @(negedge ref_clk);
    clk_en = 1;
    repeat (3) @(negedge ref_clk);
    bus(16'h7098, 0, 1);
    chk("frozen port", exp_port(16'h0f55, ext_level[7:0]), q);
    chk_pins("frozen pins", 8'h0f, 8'h55, port_pin_oe_n[7:0], port_pin_out[7:0]);
    print_verdict();
  end
endmodule // digital_io_input_and_bidir_ports_test

// ---- verif/dio_ports_monitor.sv ----
/* Bus and pin checker bound to dio_ports; assumes clk_en may drop for a few cycles. */
`timescale 1ns/1ps
module dio_ports_monitor (
  input wire        ref_clk,
  input wire        rst,
  input wire        clk_en,
  input wire        wr_en,
  input wire        rd_en,
  input wire        rd_valid,
  input wire [15:0] addr,
  input wire [15:0] wr_data,
  input wire [15:0] rd_data,
  input wire [15:0] status_a_bits,
  input wire [15:0] status_b_bits,
  input wire [31:0] port_pin_out,
  input wire [31:0] port_pin_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rv; clk_en && rd_en |=> rd_valid; endproperty
  a_rv: assert property (p_rv) else $error("no rd_valid");
  property p_hold; clk_en && !rd_en |=> $stable(rd_data) && !rd_valid; endproperty
  a_hold: assert property (p_hold) else $error("rd_data moved");
  property p_bad; clk_en && rd_en && (addr[0] || addr[15:4] != 12'h709) |=> rd_data == 16'h0; endproperty
  a_bad: assert property (p_bad) else $error("refused read");
  property p_rst; $fell(rst) |-> &port_pin_oe_n && !rd_valid; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_sa; (clk_en && $stable(status_a_bits))[*4] ##0 rd_en && addr == 16'h7094
    |=> rd_data == $past(status_a_bits); endproperty
  a_sa: assert property (p_sa) else $error("status a");
  property p_sb; (clk_en && $stable(status_b_bits))[*4] ##0 rd_en && addr == 16'h7096
    |=> rd_data == $past(status_b_bits); endproperty
  a_sb: assert property (p_sb) else $error("status b");
  property p_dir; clk_en && wr_en && addr == 16'h7098 ##1 clk_en && !wr_en
    |=> port_pin_oe_n[7:0] == ~$past(wr_data[15:8], 2); endproperty
  a_dir: assert property (p_dir) else $error("port a dir");
  property p_dirb; clk_en && wr_en && addr == 16'h709a ##1 clk_en && !wr_en
    |=> port_pin_oe_n[15:8] == ~$past(wr_data[15:8], 2); endproperty
  a_dirb: assert property (p_dirb) else $error("port b dir");
  property p_frz; !clk_en |=> $stable(port_pin_out) && $stable(port_pin_oe_n)
    && $stable(rd_data) && $stable(rd_valid); endproperty
  a_frz: assert property (p_frz) else $error("state moved while frozen");
  c_frz: cover property (!clk_en && wr_en);
  c_wra: cover property (clk_en && wr_en && addr == 16'h7098);
  c_wrb: cover property (clk_en && wr_en && addr == 16'h709a);
  c_odd: cover property (clk_en && rd_en && addr[0]);
endmodule // dio_ports_monitor
bind dio_ports dio_ports_monitor i_monitor (
  .ref_clk       (ref_clk),
  .rst           (rst),
  .clk_en        (clk_en),
  .wr_en         (wr_en),
  .rd_en         (rd_en),
  .rd_valid      (rd_valid),
  .addr          (addr),
  .wr_data       (wr_data),
  .rd_data       (rd_data),
  .status_a_bits (status_a_bits),
  .status_b_bits (status_b_bits),
  .port_pin_out  (port_pin_out),
  .port_pin_oe_n (port_pin_oe_n)
);

// ---- verif/pin_model.sv ----
/* Far-side pin model; assumes active-low output enables from the block. */
`timescale 1ns/1ps
module pin_model (
  input  wire [31:0] port_pin_out,
  input  wire [31:0] port_pin_oe_n,
  input  wire [31:0] ext_level,
  output wire [31:0] port_pin_in
);
  // Released pins follow the outside level, never a held drive value
  assign port_pin_in = (port_pin_oe_n & ext_level) | (~port_pin_oe_n & port_pin_out);
endmodule // pin_model
